//--- design/ssps_slave.sv
// two-wire slave receive and address path with its status register
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module ssps_slave
	import ssps_pkg::*;
(
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_rst_n,
	// register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// two-wire pins
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_scl_oe,
	output logic            o_sda_oe,
	output logic            o_sda_out,
	output logic            o_scl_out,
	// interrupt flag to the core
	output logic            o_port_irq
);
	// two-stage synchronisers; stage one read only by stage two
	logic [1:0] scl_s_q, sda_s_q;
	logic       scl_q, sda_q;
	always_ff @(posedge i_clock) begin
		scl_s_q <= {scl_s_q[0], i_scl};
		sda_s_q <= {sda_s_q[0], i_sda};
		scl_q   <= scl_s_q[1];
		sda_q   <= sda_s_q[1];
	end
	wire scl_now  = scl_s_q[1];
	wire sda_now  = sda_s_q[1];
	wire scl_rise = scl_now & ~scl_q;
	wire scl_fall = ~scl_now & scl_q;
	wire start_ev = scl_now & scl_q & sda_q & ~sda_now;
	wire stop_ev  = scl_now & scl_q & ~sda_q & sda_now;

	// register state
	logic [7:0]  sample_q;     // bits 7:6 writable
	logic        data_flag_q, stop_q, start_q, read_q, update_q, full_q;
	logic        ovf_q, enable_q, tenbit_q, hold_q, irq_q;
	logic [7:0]  buf_q, addr_q, shift_q;
	logic [3:0]  bitcnt_q;
	logic        ack_ok_q, is_addr_q, hi_done_q, matched_q, tx_q;
	// byte was for us even when busy refused it; gates flag updates
	logic        hit_q;
	ssps_state_t state_q;

	// decode
	wire wr_status = i_wr && (i_addr == STATUS_OFS);
	wire wr_data   = i_wr && (i_addr == DATA_OFS);
	wire wr_addr   = i_wr && (i_addr == ADDR_OFS);
	wire wr_ctrl   = i_wr && (i_addr == CONTROL_OFS);
	wire rd_data   = i_rd && (i_addr == DATA_OFS);
	wire [7:0] status_v = {sample_q[7:6], data_flag_q, stop_q, start_q,
		read_q, update_q, full_q};
	// bit 4 reads the pending clock hold, zero after reset
	wire [7:0] ctrl_v = {1'b0, ovf_q, enable_q, hold_q, 3'b000, tenbit_q};
	wire [7:0] rd_v =
		(i_addr == STATUS_OFS)  ? status_v :
		(i_addr == DATA_OFS)    ? buf_q    :
		(i_addr == ADDR_OFS)    ? addr_q   :
		(i_addr == CONTROL_OFS) ? ctrl_v   : 8'h00;

	// address match on shift contents
	wire hdr_byte  = tenbit_q && (shift_q[7:3] == TEN_HDR);
	wire match7    = ~tenbit_q && (shift_q[7:1] == addr_q[7:1]);
	wire match_hi  = hdr_byte && (shift_q[2:1] == addr_q[2:1]);
	wire match_lo  = tenbit_q && hi_done_q && (shift_q == addr_q);
	// any address form that names this slave
	wire addr_hit  = match7 | match_hi | match_lo;
	// ten-bit write header seen first: the next byte is still address,
	// so it must not count as data nor set the matched state yet
	wire hi_wr     = is_addr_q && match_hi && !shift_q[0] && !hi_done_q;
	wire busy      = full_q | ovf_q;
	wire byte_done = (bitcnt_q == 4'(BYTE_BITS)) && scl_fall;

	// read data stands one cycle after the strobe
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) o_rdata <= 8'h00;
		else          o_rdata <= i_rd ? rd_v : 8'h00;
	end

	// bus engine
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state_q <= SS_IDLE;
			bitcnt_q <= 4'h0;
			shift_q <= 8'h00;
			ack_ok_q <= 1'b0;
			is_addr_q <= 1'b0;
			hi_done_q <= 1'b0;
			matched_q <= 1'b0;
			tx_q <= 1'b0;
			o_sda_out <= 1'b1;
			hit_q <= 1'b0;
			o_sda_oe <= 1'b0;
		end else if (!enable_q) begin
			state_q <= SS_IDLE;
			o_sda_oe <= 1'b0;
			matched_q <= 1'b0;
		end else if (start_ev) begin
			// wait for start, then address
			state_q <= SS_SHIFT;
			bitcnt_q <= 4'h0;
			is_addr_q <= 1'b1;
			o_sda_oe <= 1'b0;
			if (!tx_q) hi_done_q <= 1'b0;
		end else if (stop_ev) begin
			state_q <= SS_IDLE;
			o_sda_oe <= 1'b0;
			matched_q <= 1'b0;
			tx_q <= 1'b0;
			hi_done_q <= 1'b0;
		end else begin
			case (state_q)
				SS_SHIFT: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_now};
						bitcnt_q <= bitcnt_q + 4'h1;
					end
					if (byte_done) begin
						state_q <= SS_ACK;
						// remember the match apart from the busy refusal
						hit_q <= is_addr_q ? addr_hit : matched_q;
						// ack only a clean match
						ack_ok_q <= ~busy & (is_addr_q ?
							(match7 | match_hi | match_lo) : matched_q);
						o_sda_out <= 1'b0;
						o_sda_oe <= ~busy & (is_addr_q ?
							(match7 | match_hi | match_lo) : matched_q);
					end
				end
				SS_ACK: if (scl_fall) begin // ninth falling edge
					o_sda_oe <= 1'b0;
					bitcnt_q <= 4'h0;
					// a ten-bit write header keeps the next byte an address
					is_addr_q <= hi_wr && ack_ok_q;
					if (is_addr_q && ack_ok_q && !hi_wr)
						matched_q <= 1'b1;
					if (hi_wr && ack_ok_q)
						hi_done_q <= 1'b1;
					if (is_addr_q && ack_ok_q && shift_q[0]) begin
						tx_q <= 1'b1;          // slave transmits
						state_q <= SS_TX;
						o_sda_out <= buf_q[7];
						o_sda_oe <= ~buf_q[7];
					end else if (matched_q | ack_ok_q)
						state_q <= SS_SHIFT;
					else state_q <= SS_IDLE;
				end
				SS_TX: begin
					if (scl_rise) bitcnt_q <= bitcnt_q + 4'h1;
					if (scl_fall && bitcnt_q < 4'(BYTE_BITS)) begin
						o_sda_out <= buf_q[7 - bitcnt_q[2:0]];
						o_sda_oe <= ~buf_q[7 - bitcnt_q[2:0]];
					end
					if (byte_done) begin
						o_sda_oe <= 1'b0;
						state_q <= SS_TXACK;
					end
				end
				SS_TXACK: if (scl_rise) begin
					bitcnt_q <= 4'h0;
					state_q <= sda_now ? SS_IDLE : SS_TX;
				end
				default: state_q <= SS_IDLE;
			endcase
		end
	end

	// events from the engine
	wire rx_end  = enable_q && state_q == SS_ACK && scl_fall && !start_ev
		&& !stop_ev;
	wire tx_end  = enable_q && state_q == SS_TXACK && scl_rise;
	wire load_ok = rx_end && ack_ok_q;
	// byte meant for us, whether or not busy let it into the buffer;
	// a foreign address must leave the flags and the interrupt alone
	wire rx_hit  = rx_end && hit_q;
	// the high header asks for the low byte, the low byte for the high
	wire ten_upd = tenbit_q && is_addr_q && ack_ok_q && !matched_q
		&& (match_lo || !shift_q[0]);

	// status and control registers
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			sample_q <= STATUS_RST;
			{data_flag_q, stop_q, start_q, read_q, update_q} <= 5'h00;
			full_q <= 1'b0;
			ovf_q <= 1'b0;
			enable_q <= 1'b0;
			tenbit_q <= 1'b0;
			hold_q <= 1'b0;
			irq_q <= 1'b0;
			buf_q <= 8'h00;
			addr_q <= ADDR_RST;
		end else begin
			// only mode bits are writable
			if (wr_status) sample_q <= {i_wdata[7:6], 6'h00};
			if (wr_ctrl) begin
				ovf_q <= i_wdata[CT_OVF];         // loaded by write, cleared by writing 0
				enable_q <= i_wdata[CT_ENABLE];
				tenbit_q <= i_wdata[CT_TENBIT];
				irq_q <= 1'b0;
				if (i_wdata[CT_RELEASE]) hold_q <= 1'b0;
			end
			if (wr_addr) begin
				addr_q <= i_wdata;
				update_q <= 1'b0;
				hold_q <= 1'b0;
			end
			if (wr_data) buf_q <= i_wdata;
			// read clears full
			if (rd_data) full_q <= 1'b0;
			if (wr_data) full_q <= 1'b1;
			if (tx_end) full_q <= 1'b0;
			// start and stop exclusive
			if (start_ev) begin
				start_q <= 1'b1;
				stop_q <= 1'b0;
				read_q <= 1'b0;
			end
			if (stop_ev) begin
				stop_q <= 1'b1;
				start_q <= 1'b0;
				read_q <= 1'b0;
			end
			if (!enable_q) begin
				start_q <= 1'b0;
				stop_q <= 1'b0;
			end
			// only bytes addressed to us touch the flags
			if (rx_hit) begin
				irq_q <= 1'b1;
				data_flag_q <= ~is_addr_q;
				if (!ack_ok_q && busy && matched_q) ovf_q <= 1'b1;
				if (is_addr_q && ack_ok_q) read_q <= shift_q[0];
			end
			if (load_ok) begin
				buf_q <= shift_q;
				full_q <= 1'b1;
				if (ten_upd) begin
					update_q <= 1'b1;
					hold_q <= 1'b1;
				end
			end
		end
	end

	// clock stretch while address rewrite is pending
	assign o_scl_out  = 1'b0;
	// limitation: the hold only begins once the master has pulled the
	// clock low, so a high phase already under way is never cut short
	assign o_scl_oe   = hold_q & ~scl_now;
	assign o_port_irq = irq_q;

	// checks
	buf_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		load_ok |=> full_q && buf_q == $past(shift_q))
		else $error("buffer not loaded on clean match");
	no_ack_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(state_q == SS_SHIFT && byte_done && busy && enable_q && !start_ev
		&& !stop_ev) |=> !o_sda_oe)
		else $error("ack given while busy");
	irq_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		rx_hit |=> o_port_irq)
		else $error("interrupt flag missing after ninth pulse");
	rd_clr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(rd_data && !load_ok && !wr_data) |=> !full_q)
		else $error("read did not clear full");
	ss_excl_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!(start_q && stop_q))
		else $error("start and stop both set");
	upd_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(load_ok && ten_upd && !wr_addr) |=> update_q && o_port_irq)
		else $error("update flag not raised");
	upd_clr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(wr_addr && !load_ok) |=> !update_q)
		else $error("address write kept update flag");
	dir_cap_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(rx_end && is_addr_q && ack_ok_q) |=> read_q == $past(shift_q[0]))
		else $error("direction not captured");
	// acknowledge only ever pulls the data line low
	ack_low_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		(state_q == SS_ACK && o_sda_oe) |-> !o_sda_out)
		else $error("ack driven high");
	// a refused byte after a match raises overflow
	ovf_set_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		(rx_hit && !ack_ok_q && busy && matched_q) |=> ovf_q)
		else $error("overflow not raised");
	// a refused byte never reaches the buffer
	no_load_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		(rx_end && !ack_ok_q && !wr_data) |=> buf_q == $past(buf_q))
		else $error("buffer changed on refused byte");
	// data flag follows the kind of the last byte
	flag_kind_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		rx_hit |=> data_flag_q == $past(!is_addr_q))
		else $error("data flag wrong kind");
	// stop seen sets stop and drops start
	stop_flag_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		(stop_ev && enable_q) |=> stop_q && !start_q)
		else $error("stop flag not set");
	// disabled port shows neither condition
	off_clr_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		!enable_q |=> !start_q && !stop_q)
		else $error("condition flags kept while off");
	// a finished transmit empties the buffer
	tx_empty_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		tx_end |=> !full_q)
		else $error("full kept after transmit");
	// main scenarios reached
	cov_match_c: cover property (@(posedge i_clock) load_ok);
	cov_tx_c: cover property (@(posedge i_clock) state_q == SS_TX);
	cov_busy_c: cover property (@(posedge i_clock) rx_end && !ack_ok_q);
	cov_ten_c: cover property (@(posedge i_clock) load_ok && ten_upd);
endmodule

//--- design/ssps_pkg.sv
// constants for the sync serial port two-wire slave block
package ssps_pkg;
	// register offsets (plain port, 8-bit)
	localparam logic [7:0] STATUS_OFS  = 8'h94;
	localparam logic [7:0] DATA_OFS    = 8'h13;
	localparam logic [7:0] ADDR_OFS    = 8'h93;
	localparam logic [7:0] CONTROL_OFS = 8'h14;
	// status field positions
	localparam int ST_SAMPLE  = 7;
	localparam int ST_EDGE    = 6;
	localparam int ST_DATA    = 5;
	localparam int ST_STOP    = 4;
	localparam int ST_START   = 3;
	localparam int ST_READ    = 2;
	localparam int ST_UPDATE  = 1;
	localparam int ST_FULL    = 0;
	// control field positions
	localparam int CT_OVF     = 6;
	localparam int CT_ENABLE  = 5;
	localparam int CT_RELEASE = 4;
	localparam int CT_TENBIT  = 0;
	// reset values
	localparam logic [7:0] STATUS_RST  = 8'h00;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] ADDR_RST    = 8'h00;
	// ten-bit header pattern in the top five bits
	localparam logic [4:0] TEN_HDR     = 5'h1e;
	localparam int         BYTE_BITS   = 8;
	// bus states
	typedef enum logic [2:0] {
		SS_IDLE, SS_SHIFT, SS_ACK, SS_TX, SS_TXACK
	} ssps_state_t;
endpackage

//--- tb/ssps_master.sv
// behavioural two-wire bus master driving the slave's pins
`timescale 1ns/1ps
module ssps_master (
	// wired levels seen on the bus
	input  wire logic i_scl,
	input  wire logic i_sda,
	// open-drain drive, 1 means released to the pull-up
	output logic      o_scl,
	output logic      o_sda,
	// set when the slave held the clock too long
	output logic      o_stuck
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
		o_stuck = 1'b0;
	end
	// release clock, then wait a bounded time while the slave stretches it
	task automatic rise();
		o_scl = 1'b1;
		for (int k = 0; k < 300 && !i_scl; k++) #10;
		if (!i_scl) o_stuck = 1'b1;
		#62.5;
	endtask
	// start: data falls while the clock is high
	task automatic start();
		o_sda = 1'b1;
		#31.25;
		rise();
		o_sda = 1'b0;
		#62.5;
		o_scl = 1'b0;
		#31.25;
	endtask
	// eight bits msb first, then a ninth pulse to sample the ack
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			o_sda = b[i];
			#31.25;
			rise();
			o_scl = 1'b0;
			#31.25;
		end
		o_sda = 1'b1;
		#31.25;
		rise();
		ack = !i_sda;
		o_scl = 1'b0;
		#31.25;
	endtask
	// stop: data rises while the clock is high
	task automatic stop();
		o_sda = 1'b0;
		#31.25;
		rise();
		o_sda = 1'b1;
		#62.5;
	endtask
endmodule

//--- tb/sync_serial_port_i2c_slave_test.sv
// self-checking bench for the two-wire slave and its registers
`timescale 1ns/1ps
module sync_serial_port_i2c_slave_test;
	import ssps_pkg::*;
	logic       i_clock, i_rst_n, i_wr, i_rd;
	logic [7:0] i_addr, i_wdata, o_rdata;
	logic       o_scl_oe, o_sda_oe, o_sda_out, o_port_irq;
	logic       scl_m, sda_m, stuck, ack;
	wire        scl_w, sda_w;
	int         mismatches = 0;
	int         checks_done = 0;
	// wired-and with pull-ups; slave pins sit as inputs unless driving
	assign scl_w = scl_m & ~o_scl_oe;
	assign sda_w = sda_m & (~o_sda_oe | o_sda_out);
	ssps_slave ssps_slave_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_scl(scl_w), .i_sda(sda_w),
		.o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .o_sda_out(o_sda_out),
		.o_scl_out(), .o_port_irq(o_port_irq));
	ssps_master ssps_master_inst (.i_scl(scl_w), .i_sda(sda_w),
		.o_scl(scl_m), .o_sda(sda_m), .o_stuck(stuck));
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	task automatic chk(input string n, input logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, e, input string n);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		chk(n, e, o_rdata);
	endtask
	// one byte on the bus, then let the synchronisers settle
	task automatic xb(input logic [7:0] b, input logic ea, input string n);
		ssps_master_inst.send(b, ack);
		repeat (6) @(posedge i_clock);
		chk(n, {7'h00, ea}, {7'h00, ack});
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#1ms;
		mismatches++;
		stop_test();
	end
	initial begin
		{i_rst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
		repeat (10) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rd(STATUS_OFS, 8'h00, "status rst");
		rd(CONTROL_OFS, 8'h00, "control rst");
		rd(ADDR_OFS, 8'h00, "address rst");
		rd(8'h55, 8'h00, "unmapped");
		wr(STATUS_OFS, 8'hff);
		rd(STATUS_OFS, 8'hc0, "status rw");
		wr(STATUS_OFS, 8'h00);
		wr(ADDR_OFS, 8'ha4);
		wr(CONTROL_OFS, 8'h20);
		ssps_master_inst.start();
		xb(8'ha4, 1'b1, "addr ack");
		rd(STATUS_OFS, 8'h09, "status addr");
		chk("irq", 8'h01, {7'h00, o_port_irq});
		rd(DATA_OFS, 8'ha4, "buffer");
		rd(STATUS_OFS, 8'h08, "status read");
		wr(CONTROL_OFS, 8'h20);
		xb(8'h3c, 1'b1, "data ack");
		rd(STATUS_OFS, 8'h29, "status data");
		wr(CONTROL_OFS, 8'h20);
		xb(8'h5a, 1'b0, "busy nack");
		chk("irq busy", 8'h01, {7'h00, o_port_irq});
		rd(CONTROL_OFS, 8'h60, "overflow");
		rd(DATA_OFS, 8'h3c, "buffer kept");
		wr(CONTROL_OFS, 8'h20);
		rd(CONTROL_OFS, 8'h20, "ovf clear");
		ssps_master_inst.stop();
		repeat (6) @(posedge i_clock);
		rd(STATUS_OFS, 8'h30, "status stop");
		ssps_master_inst.start();
		xb(8'h40, 1'b0, "no match");
		chk("irq idle", 8'h00, {7'h00, o_port_irq});
		ssps_master_inst.stop();
		wr(ADDR_OFS, 8'hf2);
		wr(CONTROL_OFS, 8'h21);
		ssps_master_inst.start();
		xb(8'hf2, 1'b1, "ten hdr");
		rd(STATUS_OFS, 8'h0b, "status ten1");
		wr(ADDR_OFS, 8'h34);
		rd(DATA_OFS, 8'hf2, "ten buf1");
		rd(STATUS_OFS, 8'h08, "status upd1");
		xb(8'h34, 1'b1, "ten low");
		rd(STATUS_OFS, 8'h0b, "status ten2");
		wr(ADDR_OFS, 8'hf2);
		rd(DATA_OFS, 8'h34, "ten buf2");
		rd(STATUS_OFS, 8'h08, "status upd2");
		ssps_master_inst.stop();
		wr(CONTROL_OFS, 8'h20);
		wr(ADDR_OFS, 8'ha4);
		ssps_master_inst.start();
		xb(8'ha5, 1'b1, "read addr");
		rd(STATUS_OFS, 8'h0d, "status dir");
		chk("stretch", 8'h00, {7'h00, stuck});
		stop_test();
	end
endmodule
